//--- design/cog_buffer_pkg.sv
package cog_buffer_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_SHUTDOWN = 4'h1;
  localparam logic [3:0] ADDR_RISE_PHASE = 4'h2;
  localparam logic [3:0] ADDR_FALL_PHASE = 4'h3;
  localparam logic [3:0] ADDR_RISE_DEAD = 4'h4;
  localparam logic [3:0] ADDR_FALL_DEAD = 4'h5;
  localparam logic [3:0] ADDR_RISE_BLANK = 4'h6;
  localparam logic [3:0] ADDR_FALL_BLANK = 4'h7;
  localparam logic [3:0] ADDR_INPUT_SEL = 4'h8;
  localparam logic [3:0] ADDR_ROUTE = 4'h9;
  localparam logic [3:0] ADDR_STATUS = 4'ha;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTL_ENABLE_BIT = 7;
  localparam int CTL_LOAD_BIT = 6;
  localparam int CTL_FAST_OSC_BIT = 0;
  localparam int SD_STATE_BIT = 6;
  localparam int SD_RESTART_BIT = 7;
  localparam int SD_OVR_A_BIT = 0;
  localparam int SD_OVR_B_BIT = 1;
  localparam int COUNT_WIDTH = 6;
  localparam int NUM_PINS = 4;
  localparam int NUM_INPUTS = 4;
  // ----------------------------------------
  // reset values and input modes
  // ----------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [5:0] RESET_COUNT = 6'h00;
  localparam logic [2:0] INPUT_MODE_RISE = 3'h1;
  localparam logic [2:0] INPUT_MODE_FALL = 3'h2;
  localparam logic [2:0] INPUT_MODE_FAULT = 3'h4;
  typedef struct packed {
    logic [5:0] rise_phase;
    logic [5:0] fall_phase;
    logic [5:0] rise_dead;
    logic [5:0] fall_dead;
    logic [5:0] rise_blank;
    logic [5:0] fall_blank;
  } counts_type;
  typedef enum logic [1:0] {ST_IDLE, ST_SHUTDOWN, ST_RUN} gen_state_type;
endpackage

//--- design/complementary_output_buffering.sv
// Contract
// - enabled writes wait for load request
// - disabled writes update active buffers directly
// - load copies all counts together
// - hardware clears load bit after transfer
// - one pin input: rise, fall or fault
// - each output routes to any pins
// - keeps running while sleeping
// - fast oscillator kept on in sleep
// - generator drives pin enables itself
// - auto restart clears shutdown state
// - clearing shutdown starts the generator
// - rising blank inhibits falling events
// - falling blank inhibits rising events
`timescale 1ns/100ps
module complementary_output_buffering
  import cog_buffer_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // generator timing
  input wire logic gen_clk_en,
  input wire logic sleep_mode,
  // pins
  input wire logic [NUM_INPUTS-1:0] event_pins,
  input wire logic out_a,
  input wire logic out_b,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe,
  // status to core
  output counts_type active_counts,
  output logic rise_event,
  output logic fall_event,
  output logic fault_event,
  output logic running,
  output logic fast_osc_keep
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] control_r, shutdown_r, input_sel_r, route_r;
  logic load_r;
  counts_type shadow_r, active_r;
  gen_state_type state_r, state_nxt;
  logic [NUM_INPUTS-1:0] sync1_r, sync2_r;
  logic pin_prev_r;
  logic [5:0] rblank_r, fblank_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic enabled, wr_ctl, wr_sd, sel_pin, pin_rise, pin_fall, rise_ok, fall_ok;
  logic [2:0] in_mode;
  logic [1:0] in_idx;
  logic shadow_wr;
  counts_type shadow_nxt;
  assign enabled = control_r[CTL_ENABLE_BIT];
  assign wr_ctl = reg_write && (reg_addr == ADDR_CONTROL);
  assign wr_sd = reg_write && (reg_addr == ADDR_SHUTDOWN);
  assign shadow_wr = reg_write && (reg_addr >= ADDR_RISE_PHASE) && (reg_addr <= ADDR_FALL_BLANK);
  // ----------------------------------------
  // shadow write decode
  // ----------------------------------------
  always_comb
  begin
    shadow_nxt = shadow_r;
    case (reg_addr)
      ADDR_RISE_PHASE: shadow_nxt.rise_phase = reg_wdata[5:0];
      ADDR_FALL_PHASE: shadow_nxt.fall_phase = reg_wdata[5:0];
      ADDR_RISE_DEAD: shadow_nxt.rise_dead = reg_wdata[5:0];
      ADDR_FALL_DEAD: shadow_nxt.fall_dead = reg_wdata[5:0];
      ADDR_RISE_BLANK: shadow_nxt.rise_blank = reg_wdata[5:0];
      ADDR_FALL_BLANK: shadow_nxt.fall_blank = reg_wdata[5:0];
      default: shadow_nxt = shadow_r;
    endcase
  end
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      shadow_r <= '0;
      active_r <= '0;
      load_r <= 1'b0;
    end
    else
    begin
      if (shadow_wr)
        shadow_r <= shadow_nxt;
      if (!enabled && shadow_wr)
        active_r <= shadow_nxt;
      else if (enabled && load_r && gen_clk_en)
        active_r <= shadow_r;
      if (enabled && load_r && gen_clk_en)
        load_r <= 1'b0;
      else if (wr_ctl && reg_wdata[CTL_LOAD_BIT])
        load_r <= 1'b1;
      else if (!enabled)
        load_r <= 1'b0;
    end
  end
  // ----------------------------------------
  // control, input select, route and shutdown
  // ----------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      control_r <= RESET_BYTE;
      shutdown_r <= RESET_BYTE;
      input_sel_r <= RESET_BYTE;
      route_r <= RESET_BYTE;
    end
    else
    begin
      if (wr_ctl)
        control_r <= reg_wdata;
      if (reg_write && reg_addr == ADDR_INPUT_SEL)
        input_sel_r <= reg_wdata;
      if (reg_write && reg_addr == ADDR_ROUTE)
        route_r <= reg_wdata;
      if (shutdown_r[SD_RESTART_BIT] && enabled && !wr_sd)
        shutdown_r[SD_STATE_BIT] <= 1'b0;
      else if (wr_sd)
        shutdown_r <= reg_wdata;
      if (wr_sd && reg_wdata[SD_RESTART_BIT] && enabled)
        shutdown_r[SD_STATE_BIT] <= 1'b0;
    end
  end
  // ----------------------------------------
  // generator state
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: if (enabled) state_nxt = ST_SHUTDOWN;
      ST_SHUTDOWN:
      begin
        if (!enabled)
          state_nxt = ST_IDLE;
        else if (!shutdown_r[SD_STATE_BIT])
          state_nxt = ST_RUN;
      end
      ST_RUN:
      begin
        if (!enabled)
          state_nxt = ST_IDLE;
        else if (shutdown_r[SD_STATE_BIT])
          state_nxt = ST_SHUTDOWN;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end
  // ----------------------------------------
  // input pin and blanking
  // ----------------------------------------
  assign in_idx = input_sel_r[1:0];
  assign in_mode = input_sel_r[6:4];
  assign sel_pin = sync2_r[in_idx];
  assign pin_rise = sel_pin && !pin_prev_r;
  assign pin_fall = !sel_pin && pin_prev_r;
  assign rise_ok = (fblank_r == RESET_COUNT);
  assign fall_ok = (rblank_r == RESET_COUNT);
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_r <= ST_IDLE;
      sync1_r <= '0;
      sync2_r <= '0;
      pin_prev_r <= 1'b0;
      rblank_r <= RESET_COUNT;
      fblank_r <= RESET_COUNT;
      rise_event <= 1'b0;
      fall_event <= 1'b0;
      fault_event <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      sync1_r <= event_pins;
      sync2_r <= sync1_r;
      pin_prev_r <= sel_pin;
      rise_event <= in_mode[0] && pin_rise && rise_ok && (state_r == ST_RUN);
      fall_event <= in_mode[1] && pin_fall && fall_ok && (state_r == ST_RUN);
      fault_event <= in_mode[2] && sel_pin && enabled;
      if (rise_event)
        rblank_r <= active_r.rise_blank;
      else if (gen_clk_en && rblank_r != RESET_COUNT)
        rblank_r <= rblank_r - 6'h01;
      if (fall_event)
        fblank_r <= active_r.fall_blank;
      else if (gen_clk_en && fblank_r != RESET_COUNT)
        fblank_r <= fblank_r - 6'h01;
    end
  end
  // ----------------------------------------
  // output routing
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g = g + 1)
    begin : g_route
      assign pin_out[g] = (state_r == ST_RUN) ? (route_r[g + NUM_PINS] ? out_b : out_a) :
                          (route_r[g + NUM_PINS] ? shutdown_r[SD_OVR_B_BIT] : shutdown_r[SD_OVR_A_BIT]);
      assign pin_oe[g] = route_r[g] && enabled;
    end
  endgenerate
  assign fast_osc_keep = enabled && control_r[CTL_FAST_OSC_BIT] && sleep_mode;
  assign active_counts = active_r;
  assign running = (state_r == ST_RUN);
  // ----------------------------------------
  // read back
  // ----------------------------------------
  always_comb
  begin
    case (reg_addr)
      ADDR_CONTROL: rdata_nxt = {control_r[7], load_r, control_r[5:0]};
      ADDR_SHUTDOWN: rdata_nxt = shutdown_r;
      ADDR_RISE_PHASE: rdata_nxt = {2'b00, shadow_r.rise_phase};
      ADDR_FALL_PHASE: rdata_nxt = {2'b00, shadow_r.fall_phase};
      ADDR_RISE_DEAD: rdata_nxt = {2'b00, shadow_r.rise_dead};
      ADDR_FALL_DEAD: rdata_nxt = {2'b00, shadow_r.fall_dead};
      ADDR_RISE_BLANK: rdata_nxt = {2'b00, shadow_r.rise_blank};
      ADDR_FALL_BLANK: rdata_nxt = {2'b00, shadow_r.fall_blank};
      ADDR_INPUT_SEL: rdata_nxt = input_sel_r;
      ADDR_ROUTE: rdata_nxt = route_r;
      ADDR_STATUS: rdata_nxt = {6'h00, state_r};
      default: rdata_nxt = RESET_BYTE;
    endcase
  end
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      rdata_r <= RESET_BYTE;
    else if (reg_read)
      rdata_r <= rdata_nxt;
    else
      rdata_r <= RESET_BYTE;
  end
  assign reg_rdata = rdata_r;
endmodule // complementary_output_buffering

//--- testbench/cog_buffer_checker.sv
`timescale 1ns/100ps
module cog_buffer_checker
  import cog_buffer_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // timing inputs
  input wire logic reg_write,
  input wire logic gen_clk_en,
  input wire logic sleep_mode,
  // generator status
  input wire counts_type active_counts,
  input wire logic rise_event,
  input wire logic fall_event,
  input wire logic running,
  input wire logic fast_osc_keep
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ------
  // checks
  // ------
  count_hold_a: assert property ($changed(active_counts) |-> $past(reg_write) || $past(gen_clk_en))
    else $error("counts moved without write or tick");
  rise_run_a: assert property (rise_event |-> $past(running))
    else $error("rise event while stopped");
  fall_run_a: assert property (fall_event |-> $past(running))
    else $error("fall event while stopped");
  rise_pulse_a: assert property (rise_event |=> !rise_event)
    else $error("rise event too long");
  fall_pulse_a: assert property (fall_event |-> !$past(fall_event))
    else $error("fall event too long");
  rise_blank_a: assert property (rise_event && active_counts.rise_blank != 6'h00 |=> !fall_event)
    else $error("fall not blanked");
  fall_blank_a: assert property (fall_event && active_counts.fall_blank != 6'h00 |=> !rise_event)
    else $error("rise not blanked");
  osc_sleep_a: assert property (fast_osc_keep |-> sleep_mode)
    else $error("oscillator kept while awake");
  sleep_run_a: assert property (sleep_mode && $past(sleep_mode) && $past(running) && !$past(reg_write) |-> running)
    else $error("stopped in sleep");
  cover property (rise_event && sleep_mode);
  cover property (fall_event);
  cover property ($changed(active_counts) && $past(gen_clk_en));
endmodule // cog_buffer_checker

bind complementary_output_buffering cog_buffer_checker u_cog_buffer_checker (.*);

//--- testbench/event_pin_model.sv
`timescale 1ns/100ps
module event_pin_model
(
  // clock
  input wire logic ref_clk,
  // bench request
  input wire logic [1:0] pin_sel,
  input wire logic pin_level,
  // pins
  output logic [3:0] event_pins,
  output logic out_a,
  output logic out_b
);
  // ------------
  // pin drive
  // ------------
  logic [3:0] noise_r = 4'h0;
  always @(posedge ref_clk) noise_r <= noise_r + 4'h1;
  // unselected pins wander, selected pin moves off the clock
  assign #7 event_pins = (noise_r & ~(4'h1 << pin_sel)) | ({3'h0, pin_level} << pin_sel);
  assign out_a = noise_r[1];
  assign out_b = ~noise_r[1];
endmodule // event_pin_model

//--- testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import cog_buffer_pkg::*;
  logic ref_clk = 0, sys_rst = 1, reg_write = 0, reg_read = 0, gen_clk_en = 0, sleep_mode = 0;
  logic tick_on = 0, pin_level = 0, rd_d = 0, out_a, out_b;
  logic rise_event, fall_event, fault_event, running, fast_osc_keep;
  logic [1:0] pin_sel = 2'h0;
  logic [3:0] reg_addr = 4'h0, event_pins, pin_out, pin_oe;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, v;
  counts_type active_counts, old_c, new_c;
  logic [7:0] note_q[$];
  int bad_count = 0, cmp_count = 0, rise_n = 0, fall_n = 0, seed = 81266;
  // ---------
  // harness
  // ---------
  complementary_output_buffering u_complementary_output_buffering (.*);
  event_pin_model u_event_pin_model (.ref_clk(ref_clk), .pin_sel(pin_sel), .pin_level(pin_level),
    .event_pins(event_pins), .out_a(out_a), .out_b(out_b));
  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) gen_clk_en <= tick_on & ~gen_clk_en;
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run(input int extra);
    bad_count += extra;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    cyc(1);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    note_q.push_back(e);
    cyc(1);
    reg_read <= 1'b0;
  endtask
  task automatic wait_ev(input logic fall, input int want);
    int i;
    for (i = 0; i < 200 && (fall ? fall_n : rise_n) < want; i++) @(posedge ref_clk);
    if (i == 200) complete_run(1);
  endtask
  // read data and event watcher, sampled mid-cycle where outputs are settled
  always @(posedge ref_clk)
    rd_d <= reg_read;
  always @(negedge ref_clk)
  begin
    if (rd_d) chk("rdata", reg_rdata, note_q.pop_front());
    if (rise_event === 1'b1) rise_n++;
    if (fall_event === 1'b1) fall_n++;
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int k = 0; k < 6; k++)
    begin
      v = 8'($random(seed));
      wr(ADDR_RISE_PHASE + 4'(k), v);
      old_c[35 - 6 * k -: 6] = v[5:0];
      rd(ADDR_RISE_PHASE + 4'(k), {2'b00, v[5:0]});
    end
    chk("direct", active_counts, old_c);
    rd(4'hf, 8'h00);
    wr(ADDR_SHUTDOWN, 8'h43);
    wr(ADDR_CONTROL, 8'h81);
    rd(ADDR_STATUS, 8'h01);
    tick_on <= 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      v = (k == 4) ? 8'h14 : (k == 5) ? 8'h00 : 8'($random(seed));
      wr(ADDR_RISE_PHASE + 4'(k), v);
      new_c[35 - 6 * k -: 6] = v[5:0];
    end
    chk("held", active_counts, old_c);
    tick_on <= 1'b0;
    wr(ADDR_CONTROL, 8'hc1);
    rd(ADDR_CONTROL, 8'hc1);
    chk("pending", active_counts, old_c);
    tick_on <= 1'b1;
    cyc(4);
    chk("loaded", active_counts, new_c);
    rd(ADDR_CONTROL, 8'h81);
    v = 8'($random(seed));
    wr(ADDR_ROUTE, v);
    wr(ADDR_SHUTDOWN, 8'h03);
    cyc(3);
    rd(ADDR_STATUS, 8'h02);
    chk("drivers", pin_oe, v[3:0]);
    v = 8'($random(seed));
    pin_sel <= v[1:0];
    // switch pin with event modes off so the edge detector settles first
    wr(ADDR_INPUT_SEL, {6'h00, v[1:0]});
    cyc(4);
    wr(ADDR_INPUT_SEL, {6'h0c, v[1:0]});
    sleep_mode <= 1'b1;
    cyc(3);
    chk("osc keep", fast_osc_keep, 1'b1);
    pin_level <= 1'b1;
    wait_ev(0, 1);
    pin_level <= 1'b0;
    cyc(30);
    chk("blanked", fall_n, 0);
    cyc(20);
    pin_level <= 1'b1;
    wait_ev(0, 2);
    cyc(50);
    pin_level <= 1'b0;
    wait_ev(1, 1);
    cyc(3);
    pin_level <= 1'b1;
    wait_ev(0, 3);
    chk("asleep", running, 1'b1);
    sleep_mode <= 1'b0;
    cyc(2);
    chk("osc off", fast_osc_keep, 1'b0);
    wr(ADDR_INPUT_SEL, {6'h10, pin_sel});
    cyc(6);
    chk("fault on", fault_event, 1'b1);
    pin_level <= 1'b0;
    cyc(6);
    chk("fault off", fault_event, 1'b0);
    wr(ADDR_SHUTDOWN, 8'h43);
    rd(ADDR_STATUS, 8'h01);
    chk("override", pin_out, 4'hf);
    wr(ADDR_SHUTDOWN, 8'hc3);
    cyc(3);
    rd(ADDR_STATUS, 8'h02);
    rd(ADDR_SHUTDOWN, 8'h83);
    cyc(3);
    complete_run(0);
  end
endmodule // testbench
